// ### src/udbc_counter.sv
// four-bit synchronous up/down binary counter with load, reset and cascade carry
//
// Notes on behaviour
// - load enable high copies the load value pins onto the count, no edge needed.
// - when counting is allowed, direction high increments and direction low decrements.
// - outside load and reset, count changes only on rising count clock edge, all four bits together.
// - reset pin high forces all count bits low, overriding everything else.
// - counting up, carry out is low only at count fifteen with carry in low.
// - counting down, carry out is low only at count zero with carry in low.
`timescale 1ns/10ps
module udbc_counter (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic countClk,
	input wire logic upDown,
	input wire logic loadEnable,
	input wire logic resetIn,
	input wire logic carryInN,
	input wire logic loadValueBitZero,
	input wire logic loadValueBit1,
	input wire logic loadValueBit2,
	input wire logic loadValueBitThree,
	output logic countOutBitZero,
	output logic countOutBit1,
	output logic countOutBit2,
	output logic countOutBitThree,
	output logic carryOutN
);
	import udbc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [SYNC_W-1:0] pinRaw;
	logic [SYNC_W-1:0] pinSync;

	always_comb begin
		pinRaw = SYNC_RESET_VAL;
		pinRaw[SYNC_LOAD_MSB:SYNC_LOAD_LSB] = {loadValueBitThree, loadValueBit2, loadValueBit1, loadValueBitZero};
		pinRaw[SYNC_CLK_BIT] = countClk;
		pinRaw[SYNC_DIR_BIT] = upDown;
		pinRaw[SYNC_LOADEN_BIT] = loadEnable;
		pinRaw[SYNC_RESET_BIT] = resetIn;
		pinRaw[SYNC_CARRYIN_BIT] = carryInN;
	end

	udbc_sync u_sync (
		.clk(clk),
		.sysRst(sys_rst),
		.clkEn(clkEn),
		.pinIn(pinRaw),
		.pinSync(pinSync)
	);

	logic [COUNT_W-1:0] loadValueS;
	logic countClkS;
	logic dirS;
	logic loadEnS;
	logic resetS;
	logic carryInNS;

	assign loadValueS = pinSync[SYNC_LOAD_MSB:SYNC_LOAD_LSB];
	assign countClkS = pinSync[SYNC_CLK_BIT];
	assign dirS = pinSync[SYNC_DIR_BIT];
	assign loadEnS = pinSync[SYNC_LOADEN_BIT];
	assign resetS = pinSync[SYNC_RESET_BIT];
	assign carryInNS = pinSync[SYNC_CARRYIN_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic

	udbc_state_s state_q;
	udbc_state_s state_d;

	logic countEdge;
	logic countAllowed;

	// edge taken from the synchronised copy, never from the raw pin
	assign countEdge = countClkS & ~state_q.countClkPrev;
	// carry in gates counting; load and reset are checked first below
	assign countAllowed = ~carryInNS;

	always_comb begin
		state_d = state_q;
		state_d.countClkPrev = countClkS;
		if (resetS) begin
			state_d.count = COUNT_RESET;
		end else if (loadEnS) begin
			// level-sensitive: follows the load pins every cycle it is high
			state_d.count = loadValueS;
		end else if (countEdge && countAllowed) begin
			if (dirS == DIR_UP) begin
				state_d.count = state_q.count + COUNT_STEP;
			end else begin
				state_d.count = state_q.count - COUNT_STEP;
			end
		end
		state_d.atFull = (state_d.count == COUNT_FULL);
		state_d.atZero = (state_d.count == COUNT_ZERO);
		// carry registered with the count so both move on the same edge
		state_d.carryOutN = CARRY_IDLE;
		if (!carryInNS) begin
			if (dirS == DIR_UP && state_d.atFull) begin
				state_d.carryOutN = CARRY_ACTIVE;
			end else if (dirS == DIR_DOWN && state_d.atZero) begin
				state_d.carryOutN = CARRY_ACTIVE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= STATE_RESET;
		end else if (clkEn) begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	// all four bits come from one register, so they switch together
	assign countOutBitZero = state_q.count[0];
	assign countOutBit1 = state_q.count[1];
	assign countOutBit2 = state_q.count[2];
	assign countOutBitThree = state_q.count[COUNT_W-1];
	// chaining stages adds a few cycles of carry latency per stage
	assign carryOutN = state_q.carryOutN;

endmodule : udbc_counter

// ### src/udbc_pkg.sv
// shared constants for the four-bit up/down binary counter
package udbc_pkg;

	// count width and the two terminal values
	localparam int COUNT_W = 4;
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 4'h0;
	localparam logic [COUNT_W-1:0] COUNT_FULL = 4'hF;
	localparam logic [COUNT_W-1:0] COUNT_STEP = 4'h1;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;

	// carry output is active low, so its idle level is high
	localparam logic CARRY_IDLE = 1'h1;
	localparam logic CARRY_ACTIVE = 1'h0;

	// direction input levels
	localparam logic DIR_UP = 1'h1;
	localparam logic DIR_DOWN = 1'h0;

	// layout of the pin bundle that goes through the synchroniser
	localparam int SYNC_W = 9;
	localparam int SYNC_LOAD_LSB = 0;
	localparam int SYNC_LOAD_MSB = 3;
	localparam int SYNC_CLK_BIT = 4;
	localparam int SYNC_DIR_BIT = 5;
	localparam int SYNC_LOADEN_BIT = 6;
	localparam int SYNC_RESET_BIT = 7;
	localparam int SYNC_CARRYIN_BIT = 8;

	// reset level of every synchroniser flop
	localparam logic [SYNC_W-1:0] SYNC_RESET_VAL = 9'h000;

	// whole state of the counter
	typedef struct packed {
		logic [COUNT_W-1:0] count;
		logic countClkPrev;
		logic carryOutN;
		logic atFull;
		logic atZero;
	} udbc_state_s;

	localparam udbc_state_s STATE_RESET = '{
		count: COUNT_RESET,
		countClkPrev: 1'h0,
		carryOutN: CARRY_IDLE,
		atFull: 1'h0,
		atZero: 1'h1
	};

endpackage : udbc_pkg

// ### src/udbc_sync.sv
// two-flop synchroniser bank for the counter's pin inputs
`timescale 1ns/10ps
module udbc_sync (
	input wire logic clk,
	input wire logic sysRst,
	input wire logic clkEn,
	input wire logic [udbc_pkg::SYNC_W-1:0] pinIn,
	output logic [udbc_pkg::SYNC_W-1:0] pinSync
);
	import udbc_pkg::*;

	typedef struct packed {
		logic [SYNC_W-1:0] stage1;
		logic [SYNC_W-1:0] stage2;
	} udbc_sync_s;

	udbc_sync_s state_q;
	udbc_sync_s state_d;

	// first stage feeds only the second stage
	always_comb begin
		state_d = state_q;
		state_d.stage1 = pinIn;
		state_d.stage2 = state_q.stage1;
	end

	always_ff @(posedge clk) begin
		if (sysRst) begin
			state_q <= '{stage1: SYNC_RESET_VAL, stage2: SYNC_RESET_VAL};
		end else if (clkEn) begin
			state_q <= state_d;
		end
	end

	genvar i;
	generate
		for (i = 0; i < SYNC_W; i++) begin : g_out
			assign pinSync[i] = state_q.stage2[i];
		end
	endgenerate

endmodule : udbc_sync

// ### tb/udbc_far.sv
// far-side pulse source driving the count clock
`timescale 1ns/10ps
module udbc_far (
	input wire logic clk,
	input wire logic go,
	output logic countClk
);
	logic [3:0] phase_q = 4'h0;
	// eight cycles high and eight low, well past the synchroniser's minimum width
	always @(posedge clk) begin
		if (go || phase_q != 4'h0) phase_q <= phase_q + 4'h1;
	end
	assign countClk = phase_q[3];
endmodule : udbc_far

// ### tb/udbc_asserts.sv
// concurrent checks on the counter's pins
`timescale 1ns/10ps
module udbc_asserts (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic countClk,
	input wire logic upDown,
	input wire logic loadEnable,
	input wire logic resetIn,
	input wire logic carryInN,
	input wire logic loadValueBitZero,
	input wire logic loadValueBit1,
	input wire logic loadValueBit2,
	input wire logic loadValueBitThree,
	input wire logic countOutBitZero,
	input wire logic countOutBit1,
	input wire logic countOutBit2,
	input wire logic countOutBitThree,
	input wire logic carryOutN
);
	import udbc_pkg::*;
	wire logic [3:0] q = {countOutBitThree, countOutBit2, countOutBit1, countOutBitZero};
	wire logic [3:0] pv = {loadValueBitThree, loadValueBit2, loadValueBit1, loadValueBitZero};
	logic [2:0] settle_q;
	// synchronisers hold stale zeros for a few edges after reset
	always_ff @(posedge clk) settle_q <= sys_rst ? 3'h0 : settle_q + {2'h0, settle_q != 3'h7};
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst || settle_q < 3'h5);
	reset_clr_a: assert property (resetIn [*3] |=> q == COUNT_ZERO)
		else $error("count not cleared");
	load_follow_a: assert property ((loadEnable && !resetIn && $stable(pv)) [*3] |=> q == $past(pv))
		else $error("load value not taken");
	count_hold_a: assert property ((carryInN && !loadEnable && !resetIn) [*4] |=> $stable(q))
		else $error("count moved while held");
	count_step_a: assert property (q != $past(q) && !$past(resetIn, 3) && !$past(loadEnable, 3)
		|-> q == $past(q) + ($past(upDown, 3) ? COUNT_STEP : COUNT_FULL)) else $error("bad step");
	rise_only_a: assert property (q != $past(q) && !$past(resetIn, 3) && !$past(loadEnable, 3)
		|-> $past(countClk, 3) && !$past(countClk, 4)) else $error("count without rising edge");
	carry_low_a: assert property ((!carryInN && (upDown ? q == COUNT_FULL : q == COUNT_ZERO)) [*4]
		|-> carryOutN == CARRY_ACTIVE) else $error("carry out not asserted");
	carry_idle_a: assert property ((carryInN || (upDown ? q != COUNT_FULL : q != COUNT_ZERO)) [*4]
		|-> carryOutN == CARRY_IDLE) else $error("carry out asserted wrongly");
	cover property (!carryOutN && upDown);
	cover property (!carryOutN && !upDown);
	cover property (resetIn && loadEnable);
endmodule : udbc_asserts
bind udbc_counter udbc_asserts chk_u (
	.clk(clk),
	.sys_rst(sys_rst),
	.countClk(countClk),
	.upDown(upDown),
	.loadEnable(loadEnable),
	.resetIn(resetIn),
	.carryInN(carryInN),
	.loadValueBitZero(loadValueBitZero),
	.loadValueBit1(loadValueBit1),
	.loadValueBit2(loadValueBit2),
	.loadValueBitThree(loadValueBitThree),
	.countOutBitZero(countOutBitZero),
	.countOutBit1(countOutBit1),
	.countOutBit2(countOutBit2),
	.countOutBitThree(countOutBitThree),
	.carryOutN(carryOutN)
);

// ### tb/tb_top.sv
// self-checking bench for the up/down counter
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'h0, sys_rst = 1'h1, clkEn = 1'h1, go = 1'h0, upDown = 1'h1, loadEnable = 1'h0;
	logic resetIn = 1'h0, carryInN = 1'h0, loadValueBitZero = 1'h0, loadValueBit1 = 1'h1;
	logic loadValueBit2 = 1'h1, loadValueBitThree = 1'h1;
	logic countClk, countOutBitZero, countOutBit1, countOutBit2, countOutBitThree, carryOutN;
	wire logic [4:0] outs = {carryOutN, countOutBitThree, countOutBit2, countOutBit1, countOutBitZero};
	int n_errors = 0;
	int check_count = 0;
	always #5 clk = ~clk;
	udbc_far far_u (.clk(clk), .go(go), .countClk(countClk));
	udbc_counter dut_u (
		.clk(clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.countClk(countClk),
		.upDown(upDown),
		.loadEnable(loadEnable),
		.resetIn(resetIn),
		.carryInN(carryInN),
		.loadValueBitZero(loadValueBitZero),
		.loadValueBit1(loadValueBit1),
		.loadValueBit2(loadValueBit2),
		.loadValueBitThree(loadValueBitThree),
		.countOutBitZero(countOutBitZero),
		.countOutBit1(countOutBit1),
		.countOutBit2(countOutBit2),
		.countOutBitThree(countOutBitThree),
		.carryOutN(carryOutN)
	);
	////////////////////////////////////////////////////////////////
	task chk(input string s, input logic [4:0] seen, input logic [4:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	// n count pulses, then the pipeline settles and outputs are read mid-cycle
	task tick(input int n);
		repeat (n) begin
			@(posedge clk);
			go <= 1'h1;
			@(posedge clk);
			go <= 1'h0;
			repeat (16) @(posedge clk);
		end
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask : tick
	task load_t;
		loadEnable <= 1'h1;
		tick(1);
		chk("load", outs, 5'h1E);
		@(posedge clk);
		loadEnable <= 1'h0;
		tick(1);
		chk("up to full", outs, 5'h0F);
		tick(1);
		chk("up wrap", outs, 5'h10);
	endtask : load_t
	task down_t;
		@(posedge clk);
		upDown <= 1'h0;
		tick(0);
		chk("down zero", outs, 5'h00);
		tick(1);
		chk("down wrap", outs, 5'h1F);
		@(posedge clk);
		carryInN <= 1'h1;
		tick(2);
		chk("hold", outs, 5'h1F);
		// clock enable low: a pulse with counting allowed must be missed
		@(posedge clk);
		clkEn <= 1'h0;
		carryInN <= 1'h0;
		tick(1);
		chk("frozen", outs, 5'h1F);
		@(posedge clk);
		clkEn <= 1'h1;
		carryInN <= 1'h1;
		tick(0);
		chk("thawed", outs, 5'h1F);
		@(posedge clk);
		resetIn <= 1'h1;
		loadEnable <= 1'h1;
		tick(0);
		chk("reset first", outs, 5'h10);
	endtask : down_t
	task end_of_test;
		$display("errors %0d of %0d checks", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'h0;
		load_t();
		down_t();
		end_of_test();
	end
endmodule : tb_top
